// file: dtc_pkg.sv
// Constants, register map and mode encoding for the dual timer/counter block
package dtc_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0]  IDX_CTRL   = 10'h088;
  localparam logic [9:0]  IDX_MODE   = 10'h089;
  localparam logic [9:0]  IDX_TL0    = 10'h08A;
  localparam logic [9:0]  IDX_TL1    = 10'h08B;
  localparam logic [9:0]  IDX_TH0    = 10'h08C;
  localparam logic [9:0]  IDX_TH1    = 10'h08D;
  localparam int          ADDR_W     = 12;
  // ----------------------------------------------------------------
  // Control register bit positions
  // ----------------------------------------------------------------
  localparam int          CT_TF1     = 7;
  localparam int          CT_TR1     = 6;
  localparam int          CT_TF0     = 5;
  localparam int          CT_TR0     = 4;
  localparam int          CT_IE1     = 3;
  localparam int          CT_IT1     = 2;
  localparam int          CT_IE0     = 1;
  localparam int          CT_IT0     = 0;
  // ----------------------------------------------------------------
  // Mode register bit positions
  // ----------------------------------------------------------------
  localparam int          MD_TIMER1_PIN_GATING   = 7;
  localparam int          MD_SRC1    = 6;
  localparam int          MD_MODE1   = 4;
  localparam int          MD_TIMER0_PIN_GATING   = 3;
  localparam int          MD_SRC0    = 2;
  localparam int          MD_MODE0   = 0;
  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [7:0]  BYTE_MAX   = 8'hFF;
  localparam logic [4:0]  PRESC_MAX  = 5'h1F;
  localparam int          SYS_DIV    = 12;
  localparam logic [3:0]  DIV_LAST   = 4'(SYS_DIV - 1);
  // Pin sample slots
  localparam int          PIN_X0     = 0;
  localparam int          PIN_X1     = 1;
  localparam int          PIN_A      = 2;
  localparam int          PIN_B      = 3;

  typedef enum logic [1:0] {
    MODE_PRESC,
    MODE_FULL,
    MODE_RELOAD,
    MODE_SPLIT
  } dtc_mode_t;
endpackage : dtc_pkg

// file: dtc_top.sv
// Dual timer/counter with external interrupt flags behind an APB slave
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module dtc_top
  import dtc_pkg::*;
(
  input  wire logic              CLOCK,
  input  wire logic              RST_B,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic              EXT_IRQ0_PIN_B,
  input  wire logic              EXT_IRQ1_PIN_B,
  input  wire logic              COUNT_IN_PIN_A,
  input  wire logic              COUNT_IN_PIN_B,
  input  wire logic              VECTOR_T0,
  input  wire logic              VECTOR_T1,
  input  wire logic              VECTOR_X0,
  input  wire logic              VECTOR_X1,
  output logic                   TIMER0_OVERFLOW_FLAG,
  output logic                   TIMER1_OVERFLOW_FLAG,
  output logic                   EXT_IRQ0_FLAG,
  output logic                   EXT_IRQ1_FLAG
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic dtc_hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
    dtc_hit = (a == {idx, 2'b00});
  endfunction : dtc_hit

  // One count step: {overflow, high, low}
  function automatic logic [16:0] dtc_step(input dtc_mode_t m, input logic [7:0] hi,
                                           input logic [7:0] lo, input logic inc);
    logic [8:0] s;
    s = 9'h000;
    dtc_step = {1'b0, hi, lo};
    if (inc) begin
      case (m)
        MODE_PRESC: begin
          if (lo[4:0] == PRESC_MAX) begin
            s = {1'b0, hi} + 9'h001;
            dtc_step = {s[8], s[7:0], lo[7:5], 5'h00};
          end else begin
            dtc_step = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
          end
        end
        MODE_FULL: dtc_step = {1'b0, hi, lo} + 17'h0_0001;
        MODE_RELOAD: begin
          s = {1'b0, lo} + 9'h001;
          dtc_step = s[8] ? {1'b1, hi, hi} : {1'b0, hi, s[7:0]};
        end
        MODE_SPLIT: begin
          s = {1'b0, lo} + 9'h001;
          dtc_step = {s[8], hi, s[7:0]};
        end
        default: dtc_step = {1'b0, hi, lo};
      endcase
    end
  endfunction : dtc_step

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  timer_mode_select;
  logic        tr0;
  logic        tr1;
  logic        it0;
  logic        it1;
  logic [7:0]  tl0;
  logic [7:0]  th0;
  logic [7:0]  tl1;
  logic [7:0]  th1;
  logic [3:0]  div_cnt;
  logic [3:0]  smp;
  logic [3:0]  smp_d;
  logic [3:0]  fall;
  logic [3:0]  pins;
  logic        div_tick;
  logic        acc;
  logic        wr;
  logic        wr_ctrl;
  logic        wr_mode;
  logic        wr_tl0;
  logic        wr_th0;
  logic        wr_tl1;
  logic        wr_th1;
  logic        mapped;
  logic [7:0]  rd_byte;
  dtc_mode_t   mode0;
  dtc_mode_t   mode1;
  logic        timer0_pin_gating;
  logic        timer1_pin_gating;
  logic        src0;
  logic        src1;
  logic        en0;
  logic        en1;
  logic        tick0;
  logic        tick1;
  logic        tick_th0;
  logic [16:0] next_t0;
  logic [16:0] next_t1;
  logic [8:0]  next_th0;
  logic        ovf0;
  logic        ovf1;
  logic        ovf_th0;

  // ----------------------------------------------------------------
  // APB slave: answers one cycle into the access phase
  // ----------------------------------------------------------------
  assign acc     = PSEL & PENABLE & ~PREADY;
  assign wr      = PSEL & PENABLE & PREADY & PWRITE;
  assign wr_ctrl = wr & dtc_hit(PADDR, IDX_CTRL);
  assign wr_mode = wr & dtc_hit(PADDR, IDX_MODE);
  assign wr_tl0  = wr & dtc_hit(PADDR, IDX_TL0);
  assign wr_th0  = wr & dtc_hit(PADDR, IDX_TH0);
  assign wr_tl1  = wr & dtc_hit(PADDR, IDX_TL1);
  assign wr_th1  = wr & dtc_hit(PADDR, IDX_TH1);

  always_comb begin
    mapped  = 1'b1;
    rd_byte = RST_BYTE;
    if (dtc_hit(PADDR, IDX_CTRL)) begin
      rd_byte = {TIMER1_OVERFLOW_FLAG, tr1, TIMER0_OVERFLOW_FLAG, tr0,
                 EXT_IRQ1_FLAG, it1, EXT_IRQ0_FLAG, it0};
    end else if (dtc_hit(PADDR, IDX_MODE)) begin
      rd_byte = timer_mode_select;
    end else if (dtc_hit(PADDR, IDX_TL0)) begin
      rd_byte = tl0;
    end else if (dtc_hit(PADDR, IDX_TH0)) begin
      rd_byte = th0;
    end else if (dtc_hit(PADDR, IDX_TL1)) begin
      rd_byte = tl1;
    end else if (dtc_hit(PADDR, IDX_TH1)) begin
      rd_byte = th1;
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= acc;
      PSLVERR <= acc & ~mapped;
      if (acc && !PWRITE) begin
        PRDATA <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration bits
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      timer_mode_select <= RST_BYTE;
      tr0  <= 1'b0;
      tr1  <= 1'b0;
      it0  <= 1'b0;
      it1  <= 1'b0;
    end else begin
      if (wr_mode) begin
        timer_mode_select <= PWDATA[7:0];
      end
      if (wr_ctrl) begin
        tr1 <= PWDATA[CT_TR1];
        tr0 <= PWDATA[CT_TR0];
        it1 <= PWDATA[CT_IT1];
        it0 <= PWDATA[CT_IT0];
      end
    end
  end

  assign mode0 = dtc_mode_t'(timer_mode_select[MD_MODE0 +: 2]);
  assign mode1 = dtc_mode_t'(timer_mode_select[MD_MODE1 +: 2]);
  assign timer0_pin_gating = timer_mode_select[MD_TIMER0_PIN_GATING];
  assign timer1_pin_gating = timer_mode_select[MD_TIMER1_PIN_GATING];
  assign src0  = timer_mode_select[MD_SRC0];
  assign src1  = timer_mode_select[MD_SRC1];

  // ----------------------------------------------------------------
  // Pin sampling and clock divider
  // ----------------------------------------------------------------
  assign pins = {COUNT_IN_PIN_B, COUNT_IN_PIN_A, EXT_IRQ1_PIN_B, EXT_IRQ0_PIN_B};

  // Pins arrive synchronous; two samples give the falling edge
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
          smp[gi]   <= 1'b1;
          smp_d[gi] <= 1'b1;
        end else begin
          smp[gi]   <= pins[gi];
          smp_d[gi] <= smp[gi];
        end
      end
      assign fall[gi] = smp_d[gi] & ~smp[gi];
    end
  endgenerate

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= div_tick ? 4'h0 : div_cnt + 4'h1;
    end
  end
  assign div_tick = (div_cnt == DIV_LAST);

  // ----------------------------------------------------------------
  // Count enables and steps
  // ----------------------------------------------------------------
  // Gate high lets the interrupt pin (idle high) hold the count
  assign en0   = tr0 & (~timer0_pin_gating | smp[PIN_X0]);
  assign en1   = tr1 & (~timer1_pin_gating | smp[PIN_X1]);
  assign tick0 = en0 & (src0 ? fall[PIN_A] : div_tick);
  assign tick1 = en1 & (src1 ? fall[PIN_B] : div_tick);

  // Split mode: high byte of timer 0 borrows timer 1 run control
  assign tick_th0 = (mode0 == MODE_SPLIT) & tr1 & div_tick;
  assign next_th0 = {1'b0, th0} + 9'h001;
  assign ovf_th0  = tick_th0 & next_th0[8];

  assign next_t0 = dtc_step(mode0, th0, tl0, tick0);
  assign next_t1 = (mode1 == MODE_SPLIT) ? {1'b0, th1, tl1}
                                         : dtc_step(mode1, th1, tl1, tick1);
  assign ovf0 = next_t0[16];
  assign ovf1 = next_t1[16];

  // ----------------------------------------------------------------
  // Count registers; a software write wins over a step
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      tl0 <= RST_BYTE;
      th0 <= RST_BYTE;
    end else begin
      tl0 <= wr_tl0 ? PWDATA[7:0] : next_t0[7:0];
      if (wr_th0) begin
        th0 <= PWDATA[7:0];
      end else if (tick_th0) begin
        th0 <= next_th0[7:0];
      end else if (mode0 != MODE_SPLIT) begin
        th0 <= next_t0[15:8];
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      tl1 <= RST_BYTE;
      th1 <= RST_BYTE;
    end else begin
      tl1 <= wr_tl1 ? PWDATA[7:0] : next_t1[7:0];
      th1 <= wr_th1 ? PWDATA[7:0] : next_t1[15:8];
    end
  end

  // ----------------------------------------------------------------
  // Flags: a hardware set wins over any clear
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      TIMER0_OVERFLOW_FLAG <= 1'b0;
      TIMER1_OVERFLOW_FLAG <= 1'b0;
    end else begin
      if (ovf0) begin
        TIMER0_OVERFLOW_FLAG <= 1'b1;
      end else if (wr_ctrl) begin
        TIMER0_OVERFLOW_FLAG <= PWDATA[CT_TF0];
      end else if (VECTOR_T0) begin
        TIMER0_OVERFLOW_FLAG <= 1'b0;
      end
      if (ovf1 || ovf_th0) begin
        TIMER1_OVERFLOW_FLAG <= 1'b1;
      end else if (wr_ctrl) begin
        TIMER1_OVERFLOW_FLAG <= PWDATA[CT_TF1];
      end else if (VECTOR_T1) begin
        TIMER1_OVERFLOW_FLAG <= 1'b0;
      end
    end
  end

  // Level mode simply mirrors the pin, so it cannot be cleared early
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      EXT_IRQ0_FLAG <= 1'b0;
      EXT_IRQ1_FLAG <= 1'b0;
    end else begin
      if (!it0) begin
        EXT_IRQ0_FLAG <= ~smp[PIN_X0];
      end else if (fall[PIN_X0]) begin
        EXT_IRQ0_FLAG <= 1'b1;
      end else if (wr_ctrl) begin
        EXT_IRQ0_FLAG <= PWDATA[CT_IE0];
      end else if (VECTOR_X0) begin
        EXT_IRQ0_FLAG <= 1'b0;
      end
      if (!it1) begin
        EXT_IRQ1_FLAG <= ~smp[PIN_X1];
      end else if (fall[PIN_X1]) begin
        EXT_IRQ1_FLAG <= 1'b1;
      end else if (wr_ctrl) begin
        EXT_IRQ1_FLAG <= PWDATA[CT_IE1];
      end else if (VECTOR_X1) begin
        EXT_IRQ1_FLAG <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking dtc_cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_B);

  sequence s_reload1;
    tick1 && mode1 == MODE_RELOAD && tl1 == BYTE_MAX && !wr_tl1 && !wr_th1;
  endsequence

  sequence s_split_wrap;
    mode0 == MODE_SPLIT && tr1 && div_tick && th0 == BYTE_MAX && !wr_th0;
  endsequence

  t1_flag_set_a: assert property ((ovf1 || ovf_th0) |=> TIMER1_OVERFLOW_FLAG)
    else $error("timer 1 overflow did not set flag");
  t0_vec_clr_a: assert property (VECTOR_T0 && !ovf0 && !wr_ctrl |=> !TIMER0_OVERFLOW_FLAG)
    else $error("timer 0 flag not cleared on vector");
  t0_run_stop_a: assert property (!tr0 && !wr_tl0 |=> tl0 == $past(tl0))
    else $error("stopped timer 0 low byte moved");
  x1_edge_a: assert property (it1 && fall[PIN_X1] ##1 it1 |-> EXT_IRQ1_FLAG [*1])
    else $error("falling edge on pin 1 not flagged");
  x0_level_a: assert property (!it0 |=> EXT_IRQ0_FLAG != $past(smp[PIN_X0]))
    else $error("level flag does not mirror pin 0");
  x0_edge_a: assert property (it0 && fall[PIN_X0] |=> EXT_IRQ0_FLAG)
    else $error("falling edge on pin 0 not flagged");
  t1_gate_hold_a: assert property (timer1_pin_gating && !smp[PIN_X1] && !wr_tl1 && !wr_th1
                                   |=> $stable({th1, tl1}))
    else $error("gated timer 1 counted");
  t0_gate_hold_a: assert property (timer0_pin_gating && !smp[PIN_X0] && mode0 != MODE_SPLIT
                                   && !wr_tl0 && !wr_th0 |=> $stable({th0, tl0}))
    else $error("gated timer 0 counted");
  t1_pin_count_a: assert property (en1 && src1 && mode1 == MODE_FULL && fall[PIN_B]
                                   && !wr_tl1 && !wr_th1
                                   |=> {th1, tl1} == $past({th1, tl1}) + 16'h0001)
    else $error("timer 1 missed a pin edge");
  t0_src_hold_a: assert property (src0 && !fall[PIN_A] && !wr_tl0 |=> $stable(tl0))
    else $error("timer 0 counted without a pin edge");
  t0_presc_a: assert property (tick0 && mode0 == MODE_PRESC && tl0[4:0] != PRESC_MAX
                               && !wr_th0 |=> $stable(th0))
    else $error("prescaler carried early");
  t1_reload_a: assert property (s_reload1 |=> tl1 == $past(th1) && TIMER1_OVERFLOW_FLAG)
    else $error("timer 1 reload failed");
  t1_halt_a: assert property (mode1 == MODE_SPLIT && !wr_tl1 && !wr_th1
                              |=> $stable({th1, tl1}))
    else $error("timer 1 moved in mode 3");
  t0_split_a: assert property (s_split_wrap |=> TIMER1_OVERFLOW_FLAG && th0 == RST_BYTE)
    else $error("split high byte wrap not flagged");
  apb_ready_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("apb answer not one cycle");

endmodule : dtc_top

// file: dtc_cpu_model.sv
// Interrupt handler model: answers pending flags with vector pulses
`timescale 1ns/1ps
module dtc_cpu_model (
  input  wire logic       clock,
  input  wire logic [3:0] flags,
  input  wire logic [3:0] ack_en,
  input  wire logic [3:0] delay,
  output logic      [3:0] vec
);
  int cnt [4];

  initial vec = 4'h0;

  // ----------------------------------------------------------------
  // Vector acknowledge
  // ----------------------------------------------------------------
  // One pulse per pending flag after a settable wait, so both prompt and
  // slow service are exercised; never pulses for a flag that is low
  always @(posedge clock) begin
    for (int i = 0; i < 4; i++) begin
      if (vec[i] || !(flags[i] && ack_en[i])) begin
        vec[i] <= 1'b0;
        cnt[i] = 0;
      end else if (cnt[i] >= int'(delay)) begin
        vec[i] <= 1'b1;
      end else begin
        cnt[i]++;
      end
    end
  end
endmodule : dtc_cpu_model

// file: dual_timer_counter_ext_irq_tb.sv
// Self-checking bench for the dual timer/counter with external irq flags
`timescale 1ns/1ps
module dual_timer_counter_ext_irq_tb
  import dtc_pkg::*;
;
  logic              CLOCK   = 1'b0;
  logic              RST_B   = 1'b0;
  logic              PSEL    = 1'b0;
  logic              PENABLE = 1'b0;
  logic              PWRITE  = 1'b0;
  logic [ADDR_W-1:0] PADDR   = '0;
  logic [31:0]       PWDATA  = '0;
  logic [31:0]       PRDATA;
  logic              PREADY;
  logic              PSLVERR;
  logic [3:0]        pin     = 4'hF;
  logic [3:0]        ack_en  = 4'h0;
  logic [3:0]        dly     = 4'h0;
  logic [3:0]        vec;
  logic [3:0]        flg;
  int                n_fail  = 0;
  int                n_checks = 0;
  integer            seed    = 32'hc96e_cff1;

  initial forever #50 CLOCK = ~CLOCK;

  dtc_top dut (
    .CLOCK(CLOCK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .EXT_IRQ0_PIN_B(pin[2]), .EXT_IRQ1_PIN_B(pin[3]),
    .COUNT_IN_PIN_A(pin[0]), .COUNT_IN_PIN_B(pin[1]),
    .VECTOR_T0(vec[0]), .VECTOR_T1(vec[1]), .VECTOR_X0(vec[2]), .VECTOR_X1(vec[3]),
    .TIMER0_OVERFLOW_FLAG(flg[0]), .TIMER1_OVERFLOW_FLAG(flg[1]),
    .EXT_IRQ0_FLAG(flg[2]), .EXT_IRQ1_FLAG(flg[3])
  );

  dtc_cpu_model cpu (.clock(CLOCK), .flags(flg), .ack_en(ack_en), .delay(dly), .vec(vec));

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // ----------------------------------------------------------------
  // Bus and pin drivers
  // ----------------------------------------------------------------
  task automatic cycles(input int n);
    repeat (n) @(posedge CLOCK);
  endtask : cycles

  task automatic apb(input logic wr_en, input logic [9:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    int k;
    @(posedge CLOCK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr_en;
    PADDR   <= {idx, 2'b00};
    PWDATA  <= 32'(wd);
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    k = 0;
    // Ready sampled at the edge itself, before the slave's update lands
    do begin
      @(posedge CLOCK);
      k++;
    end while (PREADY !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_fail++;
      tally_and_finish();
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
  endtask : wr

  task automatic rd_chk(input string what, input logic [9:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 8'h00, r, e);
    check(what, r, exp);
  endtask : rd_chk

  task automatic pulse(input int p, input int n);
    repeat (n) begin
      @(posedge CLOCK);
      pin[p] <= 1'b0;
      cycles(3);
      pin[p] <= 1'b1;
      cycles(2);
    end
    cycles(3);
  endtask : pulse

  task automatic ack(input int i);
    int k;
    @(posedge CLOCK);
    ack_en[i] <= 1'b1;
    dly <= 4'($unsigned($random(seed)) % 6);
    for (k = 0; k < 30 && flg[i] !== 1'b0; k++) @(posedge CLOCK);
    ack_en[i] <= 1'b0;
    if (k >= 30) begin
      n_fail++;
      tally_and_finish();
    end
    check("flag after vector", 32'(flg[i]), 32'h0000_0000);
  endtask : ack

  // ----------------------------------------------------------------
  // Reference count model
  // ----------------------------------------------------------------
  function automatic void step(input int t, input int m, inout int th, inout int tl,
                               inout int ovf);
    case (m)
      0: begin
        tl = (tl & 8'hE0) | ((tl + 1) & 8'h1F);
        if ((tl & 8'h1F) == 0) begin
          th = (th + 1) & 8'hFF;
          if (th == 0) ovf = 1;
        end
      end
      1: begin
        tl = (tl + 1) & 8'hFF;
        if (tl == 0) begin
          th = (th + 1) & 8'hFF;
          if (th == 0) ovf = 1;
        end
      end
      2: begin
        tl = (tl + 1) & 8'hFF;
        if (tl == 0) begin
          tl = th;
          ovf = 1;
        end
      end
      default: if (t == 0) begin
        tl = (tl + 1) & 8'hFF;
        if (tl == 0) ovf = 1;
      end
    endcase
  endfunction : step

  // Counter-mode run on one timer; gl holds the gating pin low
  task automatic run_count(input int t, input int m, input int gate, input int gl, input int n);
    int         th;
    int         tl;
    int         ovf;
    logic [9:0] ith;
    logic [9:0] itl;
    th  = (m >= 2) ? ($unsigned($random(seed)) & 8'hFF) : 8'hFF;
    tl  = 8'hF8 | ($unsigned($random(seed)) & 8'h07);
    ith = t ? IDX_TH1 : IDX_TH0;
    itl = t ? IDX_TL1 : IDX_TL0;
    ovf = 0;
    wr(IDX_CTRL, 8'h00);
    wr(IDX_MODE, 8'(((gate << 3) | 4 | m) << (4 * t)));
    wr(ith, 8'(th));
    wr(itl, 8'(tl));
    @(posedge CLOCK);
    pin[2 + t] <= (gl == 0);
    wr(IDX_CTRL, 8'(1 << (t ? CT_TR1 : CT_TR0)));
    pulse(t, n);
    if (!(gate && gl)) repeat (n) step(t, m, th, tl, ovf);
    check("overflow flag", 32'(flg[t]), 32'(ovf));
    if (ovf != 0) ack(t);
    wr(IDX_CTRL, 8'h00);
    @(posedge CLOCK);
    pin[2 + t] <= 1'b1;
    rd_chk("high byte", ith, 32'(th));
    rd_chk("low byte", itl, 32'(tl));
  endtask : run_count

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic        e;
    logic [7:0]  d;
    logic [9:0]  regs [6];
    regs = '{IDX_CTRL, IDX_MODE, IDX_TL0, IDX_TL1, IDX_TH0, IDX_TH1};
    cycles(3);
    RST_B <= 1'b1;
    foreach (regs[i]) rd_chk("reset value", regs[i], 32'h0000_0000);
    check("flags after reset", 32'(flg), 32'h0000_0000);
    apb(1'b0, 10'h090, 8'h00, r, e);
    check("unmapped error", 32'(e), 32'h0000_0001);
    check("unmapped data", r, 32'h0000_0000);
    d = 8'($random(seed));
    wr(IDX_MODE, d);
    rd_chk("mode readback", IDX_MODE, 32'(d));
    for (int x = 0; x < 2; x++) begin
      for (int typ = 0; typ < 2; typ++) begin
        wr(IDX_CTRL, 8'(typ << (x ? CT_IT1 : CT_IT0)));
        @(posedge CLOCK);
        pin[2 + x] <= 1'b0;
        cycles(4);
        check("irq flag set", 32'(flg[2 + x]), 32'h0000_0001);
        pin[2 + x] <= 1'b1;
        cycles(4);
        check("irq after release", 32'(flg[2 + x]), 32'(typ));
        if (typ != 0) ack(2 + x);
      end
    end
    for (int t = 0; t < 2; t++) begin
      for (int m = 0; m < 4; m++) run_count(t, m, 0, 0, 10);
      run_count(t, 1, 1, 1, 10);
      run_count(t, 1, 1, 0, 10);
      // Divided clock: divider phase is free-running, so allow one tick of slack
      wr(IDX_CTRL, 8'h00);
      wr(IDX_MODE, 8'(1 << (4 * t)));
      wr(t ? IDX_TL1 : IDX_TL0, 8'h00);
      wr(IDX_CTRL, 8'(1 << (t ? CT_TR1 : CT_TR0)));
      cycles(120);
      wr(IDX_CTRL, 8'h00);
      apb(1'b0, t ? IDX_TL1 : IDX_TL0, 8'h00, r, e);
      check("divided ticks", 32'(r >= 9 && r <= 11), 32'h0000_0001);
      cycles(60);
      rd_chk("stopped count", t ? IDX_TL1 : IDX_TL0, r);
    end
    // Split mode: high byte of timer 0 runs on timer 1's run bit, wrap raises timer 1 flag
    wr(IDX_CTRL, 8'h00);
    wr(IDX_MODE, 8'h03);
    wr(IDX_TH0, 8'hFF);
    wr(IDX_CTRL, 8'(1 << CT_TR1));
    cycles(30);
    check("split wrap flag", 32'(flg[1]), 32'h0000_0001);
    ack(1);
    wr(IDX_CTRL, 8'h00);
    apb(1'b0, IDX_TH0, 8'h00, r, e);
    check("split high byte", 32'(r < 8), 32'h0000_0001);
    tally_and_finish();
  end
endmodule : dual_timer_counter_ext_irq_tb
